// *** rtl/fpds_top.sv ***
// Front panel switch matrix, display oscillator, strobe decoder and drivers.
// Assumes memory-board inputs are asynchronous and pass two flip-flops.
// Operation
// - Pushbuttons form four columns by eight rows, read by the controller.
// - Produce nominal 125 Hz square wave to drivers, complement to memory board.
// - Digit drivers decode weighted BCD to segments a-g while strobed.
// - Unstrobed digit drivers hold last decoded segments, ignoring BCD changes.
// - Inhibit high forces all sixteen strobes low and captures address.
// - Inhibit pulsed low raises only the decoded strobe for its duration.
// - Status drivers latch per driver, each with its four strobes tied together.
// - One status driver has fourth strobe high, driving common pins low.
`timescale 1ns/10ps
`default_nettype none
module fpds_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [`FPDS_COLS-1:0] i_col_drive_n,
  input wire logic [`FPDS_COLS*`FPDS_ROWS-1:0] i_key_pressed,
  output logic [`FPDS_ROWS-1:0] o_row_n,
  input wire fpds_pkg::fpds_strobe_req_t i_strobe_req,
  input wire logic [`FPDS_DIGITS*4-1:0] i_bcd,
  input wire logic [`FPDS_STATUS-1:0] i_status_strobe,
  input wire logic [`FPDS_STATUS*4-1:0] i_status_data,
  output logic o_display_frequency_input,
  output logic o_display_frequency_n,
  output logic [`FPDS_DIGITS-1:0] o_digit_strobe,
  output logic [`FPDS_DIGITS*7-1:0] o_digit_seg,
  output logic [`FPDS_STATUS*4-1:0] o_status_seg
);
  // Two-flop synchronisers, one block per pin group
  fpds_pkg::fpds_strobe_req_t req_s1_q;
  fpds_pkg::fpds_strobe_req_t req_s2_q;
  logic [`FPDS_COLS-1:0] col_s1_q;
  logic [`FPDS_COLS-1:0] col_s2_q;
  logic [`FPDS_COLS*`FPDS_ROWS-1:0] key_s1_q;
  logic [`FPDS_COLS*`FPDS_ROWS-1:0] key_s2_q;
  logic [`FPDS_DIGITS*4-1:0] bcd_s1_q;
  logic [`FPDS_DIGITS*4-1:0] bcd_s2_q;
  logic [`FPDS_STATUS-1:0] sst_s1_q;
  logic [`FPDS_STATUS-1:0] sst_s2_q;
  logic [`FPDS_STATUS*4-1:0] sdat_s1_q;
  logic [`FPDS_STATUS*4-1:0] sdat_s2_q;

  // Resets inhibited, so no strobe escapes while the board wakes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      req_s1_q <= '{addr: 4'h0, inhibit: 1'b1};
      req_s2_q <= '{addr: 4'h0, inhibit: 1'b1};
    end else begin
      req_s1_q <= i_strobe_req;
      req_s2_q <= req_s1_q;
    end
  end

  // Columns idle high, no column selected
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      col_s1_q <= '1;
      col_s2_q <= '1;
    end else begin
      col_s1_q <= i_col_drive_n;
      col_s2_q <= col_s1_q;
    end
  end

  // Contact bounce is left to the controller's repeated scan
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      key_s1_q <= '0;
      key_s2_q <= '0;
    end else begin
      key_s1_q <= i_key_pressed;
      key_s2_q <= key_s1_q;
    end
  end

  // Same depth as the strobe path, so data and strobe stay aligned
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bcd_s1_q <= '0;
      bcd_s2_q <= '0;
    end else begin
      bcd_s1_q <= i_bcd;
      bcd_s2_q <= bcd_s1_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sst_s1_q <= '0;
      sst_s2_q <= '0;
    end else begin
      sst_s1_q <= i_status_strobe;
      sst_s2_q <= sst_s1_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sdat_s1_q <= '0;
      sdat_s2_q <= '0;
    end else begin
      sdat_s1_q <= i_status_data;
      sdat_s2_q <= sdat_s1_q;
    end
  end

  // Key matrix: a row reads low if any driven-low column has that key pressed
  wire [`FPDS_ROWS-1:0] row_hit;
  logic [`FPDS_ROWS-1:0] row_n_q;
  genvar g;
  generate
    for (g = 0; g < `FPDS_ROWS; g++) begin : gen_row
      logic hit;
      always_comb begin
        hit = 1'b0;
        for (int c = 0; c < `FPDS_COLS; c++) begin
          if (!col_s2_q[c] && key_s2_q[c*`FPDS_ROWS+g]) begin
            hit = 1'b1;
          end
        end
      end
      assign row_hit[g] = hit;
    end
  endgenerate
  // Registered, so rows answer three edges after a column change
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      row_n_q <= '1;
    end else begin
      row_n_q <= ~row_hit;
    end
  end
  assign o_row_n = row_n_q;

  // Display oscillator: a divider stands in for the astable, so the rate is exact
  logic [`FPDS_CNT_W-1:0] osc_cnt_q;
  logic osc_wrap;
  logic osc_q;
  assign osc_wrap = (osc_cnt_q == `FPDS_CNT_W'(`FPDS_HALF_CYC - 1));
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      osc_cnt_q <= '0;
    end else if (osc_wrap) begin
      osc_cnt_q <= '0;
    end else begin
      osc_cnt_q <= osc_cnt_q + `FPDS_CNT_W'(1);
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      osc_q <= 1'b0;
    end else if (osc_wrap) begin
      osc_q <= ~osc_q;
    end
  end
  assign o_display_frequency_input = osc_q;
  // Complement goes to the memory board
  assign o_display_frequency_n = ~osc_q;

  // Digit strobe decoder: address latched while inhibited
  logic [3:0] addr_q;
  wire [`FPDS_DIGITS-1:0] strobe_d;
  logic [`FPDS_DIGITS-1:0] strobe_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      addr_q <= 4'h0;
    end else if (req_s2_q.inhibit) begin
      addr_q <= req_s2_q.addr;
    end
  end

  // Latched address used, so mid-pulse address changes are ignored
  generate
    for (g = 0; g < `FPDS_DIGITS; g++) begin : gen_decode
      assign strobe_d[g] = (addr_q == 4'(g));
    end
  endgenerate
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      strobe_q <= '0;
    end else if (req_s2_q.inhibit) begin
      strobe_q <= '0;
    end else begin
      strobe_q <= strobe_d;
    end
  end
  assign o_digit_strobe = strobe_q;

  // Segment latches sit in the driver module
  generate
    for (g = 0; g < `FPDS_DIGITS; g++) begin : gen_digit
      fpds_digit_driver u_digit (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_strobe(strobe_q[g]),
        .i_bcd(bcd_s2_q[g*4 +: 4]),
        .o_seg(o_digit_seg[g*7 +: 7])
      );
    end
  endgenerate

  // Status drivers, commoned strobe per driver
  wire [`FPDS_STATUS*4-1:0] sseg;
  generate
    for (g = 0; g < `FPDS_STATUS; g++) begin : gen_status
      logic [3:0] seg_q;
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          seg_q <= 4'h0;
        end else if (sst_s2_q[g]) begin
          seg_q <= sdat_s2_q[g*4 +: 4];
        end
      end
      assign sseg[g*4 +: 4] = seg_q;
    end
  endgenerate

  // Common pin driver: fourth strobe tied high, segment carries the 0 V level
  always_comb begin
    o_status_seg = sseg;
    o_status_seg[(`FPDS_STATUS-1)*4 + `FPDS_COMMON_SEG] = 1'b0;
  end
endmodule
`default_nettype wire

// *** rtl/fpds_regs.svh ***
// Constants for the front panel display strobe block.
// Assumes a 100 MHz system clock.
`ifndef FPDS_REGS_SVH
`define FPDS_REGS_SVH
`define FPDS_CLK_HZ 100000000
`define FPDS_DISP_HZ 125
`define FPDS_HALF_CYC (`FPDS_CLK_HZ / (2 * `FPDS_DISP_HZ))
`define FPDS_CNT_W 19
`define FPDS_DIGITS 16
`define FPDS_STATUS 4
`define FPDS_COLS 4
`define FPDS_ROWS 8
`define FPDS_SEG_BLANK 7'h00
`define FPDS_COMMON_SEG 3
`endif

// *** rtl/fpds_pkg.sv ***
// Types shared by the front panel display strobe block.
// Assumes fpds_regs.svh is included first.
`include "fpds_regs.svh"
package fpds_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic inhibit;
  } fpds_strobe_req_t;
  typedef logic [6:0] fpds_seg7_t;
  typedef logic [3:0] fpds_seg4_t;
endpackage

// *** rtl/fpds_digit_driver.sv ***
// One BCD to seven-segment driver that follows while strobed, else holds.
// Assumes strobe and BCD are synchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
module fpds_digit_driver (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_strobe,
  input wire logic [3:0] i_bcd,
  output logic [6:0] o_seg
);
  logic [6:0] dec;
  logic [6:0] seg_q;
  // Segment order {g,f,e,d,c,b,a}
  always_comb begin
    case (i_bcd)
      4'h0: dec = 7'h3f;
      4'h1: dec = 7'h06;
      4'h2: dec = 7'h5b;
      4'h3: dec = 7'h4f;
      4'h4: dec = 7'h66;
      4'h5: dec = 7'h6d;
      4'h6: dec = 7'h7d;
      4'h7: dec = 7'h07;
      4'h8: dec = 7'h7f;
      4'h9: dec = 7'h6f;
      default: dec = `FPDS_SEG_BLANK;
    endcase
  end
  // Registered, so a follow shows one cycle late
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      seg_q <= `FPDS_SEG_BLANK;
    end else if (i_strobe) begin
      seg_q <= dec;
    end
    // Hold otherwise
  end
  assign o_seg = seg_q;
endmodule
`default_nettype wire

// *** verif/fpds_assertions.sv ***
// Port checker for the display strobe block.
// Assumes one clock domain and a bind onto fpds_top.
`timescale 1ns/10ps
`default_nettype none
module fpds_assertions (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_col_drive_n,
  input wire fpds_pkg::fpds_strobe_req_t i_strobe_req,
  input wire logic [3:0] i_status_strobe,
  input wire logic o_display_frequency_input,
  input wire logic o_display_frequency_n,
  input wire logic [7:0] o_row_n,
  input wire logic [15:0] o_digit_strobe,
  input wire logic [111:0] o_digit_seg,
  input wire logic [15:0] o_status_seg
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_freq_complement: assert property (o_display_frequency_n != o_display_frequency_input)
    else $error("square phases equal");
  a_strobe_onehot: assert property ($onehot0(o_digit_strobe))
    else $error("two strobes high");
  a_inhibit_clears: assert property ((i_strobe_req.inhibit)[*4] |-> !o_digit_strobe)
    else $error("strobe under inhibit");
  a_pulse_strobes: assert property ((!i_strobe_req.inhibit)[*4] |-> |o_digit_strobe)
    else $error("no strobe in pulse");
  a_digit_hold: assert property ((!o_digit_strobe)[*3] |-> $stable(o_digit_seg))
    else $error("digit moved unstrobed");
  a_status_hold: assert property ((!i_status_strobe)[*5] |-> $stable(o_status_seg))
    else $error("status moved unstrobed");
  a_common_low: assert property (!o_status_seg[15])
    else $error("common segment high");
  a_rows_idle: assert property ((&i_col_drive_n)[*4] |-> &o_row_n)
    else $error("row low, no column");
endmodule
bind fpds_top fpds_assertions u_chk (.i_clk, .i_rst, .i_col_drive_n, .i_strobe_req,
  .i_status_strobe, .o_display_frequency_input, .o_display_frequency_n, .o_row_n,
  .o_digit_strobe, .o_digit_seg, .o_status_seg);
`default_nettype wire

// *** verif/fpds_board_model.sv ***
// Memory board stand-in: column scan and strobe request pulses.
// Assumes the bench calls put from one procedure.
`timescale 1ns/10ps
`default_nettype none
module fpds_board_model (
  input wire logic i_clk,
  output logic [3:0] o_col_drive_n,
  output var fpds_pkg::fpds_strobe_req_t o_strobe_req
);
  initial begin
    o_col_drive_n = 4'hf;
    o_strobe_req = '{addr: 4'h0, inhibit: 1'b1};
  end
  // Falling edge keeps changes clear of the sampling edge
  task automatic put(input logic [3:0] a, input logic inh, input logic [3:0] c, input int n);
    @(negedge i_clk);
    o_strobe_req = '{addr: a, inhibit: inh};
    o_col_drive_n = c;
    repeat (n - 1) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the front panel display strobe block.
// Assumes the board model drives columns and strobe requests.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic i_clk = 1'b0, i_rst = 1'b1, fq, fqn;
  logic [31:0] key = 32'h0;
  logic [63:0] bcd = 64'h0;
  logic [3:0] sst = 4'h0, cols;
  logic [15:0] sdat = 16'h0, dstb, sseg;
  logic [7:0] rows;
  logic [111:0] dseg;
  fpds_pkg::fpds_strobe_req_t req;
  logic [6:0] pat [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f,
    7'h6f, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
  int num_errors = 0, samples_checked = 0, cyc = 0;
  fpds_board_model board (.i_clk, .o_col_drive_n(cols), .o_strobe_req(req));
  fpds_top uut (.i_clk, .i_rst, .i_col_drive_n(cols), .i_key_pressed(key), .o_row_n(rows),
    .i_strobe_req(req), .i_bcd(bcd), .i_status_strobe(sst), .i_status_data(sdat),
    .o_display_frequency_input(fq), .o_display_frequency_n(fqn), .o_digit_strobe(dstb),
    .o_digit_seg(dseg), .o_status_seg(sseg));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic t_digits;
    for (int g = 0; g < 16; g++) begin
      bcd[g*4+:4] = 4'(g);
      board.put(4'(g), 1'b1, 4'hf, 4);
      board.put(4'(g), 1'b0, 4'hf, 3);
      // Address moved mid-pulse must not retarget the strobe
      board.put(4'(g + 1), 1'b0, 4'hf, 5);
      chk("strobe", 16'h0001 << g, dstb);
      chk("digit", pat[g], dseg[g*7+:7]);
      // Still strobed: a new code must show through
      bcd[g*4+:4] = 4'(g + 6);
      board.put(4'(g + 1), 1'b0, 4'hf, 4);
      chk("digit follows", pat[(g + 6) % 16], dseg[g*7+:7]);
      board.put(4'(g), 1'b1, 4'hf, 4);
      chk("strobe off", 16'h0000, dstb);
      bcd[g*4+:4] = 4'(g + 1);
      board.put(4'(g), 1'b1, 4'hf, 4);
      chk("digit held", pat[(g + 6) % 16], dseg[g*7+:7]);
    end
    $display("test digits done");
  endtask
  task automatic t_keys;
    for (int c = 0; c < 4; c++) begin
      key = (32'h1 << (c * 10 + 1)) | (32'h1 << ((c + 1) % 4 * 8));
      board.put(4'h0, 1'b1, {~(4'h1 << c)}, 4);
      chk("rows", {~(8'h01 << (2 * c + 1))}, rows);
    end
    board.put(4'h0, 1'b1, 4'hf, 4);
    chk("rows idle", 8'hff, rows);
    $display("test keys done");
  endtask
  task automatic t_status;
    sst = 4'hf;
    sdat = 16'ha5f3;
    board.put(4'h0, 1'b1, 4'hf, 5);
    chk("status", 16'h25f3, sseg);
    sst = 4'h0;
    sdat = 16'h5a0c;
    board.put(4'h0, 1'b1, 4'hf, 5);
    chk("status held", 16'h25f3, sseg);
    sst = 4'h5;
    board.put(4'h0, 1'b1, 4'hf, 5);
    chk("status part", 16'h2afc, sseg);
    // Half period is far beyond this run, so the square must not have moved yet
    chk("square slow", 2'h1, {fq, fqn});
    chk("square count", 32'(cyc - 10), 32'(uut.osc_cnt_q));
    $display("test status done");
  endtask
  initial begin
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    chk("square", 2'h1, {fq, fqn});
    chk("reset strobes", 16'h0000, dstb);
    chk("reset digits", 112'h0, dseg);
    chk("reset rows", 8'hff, rows);
    chk("reset status", 16'h0000, sseg);
    $display("test reset done");
    t_digits();
    t_keys();
    t_status();
    print_verdict();
  end
endmodule
`default_nettype wire
